// >>> verilog/addr_gen_pkg.sv
/*
  Constants and carrier types for the effective data-address generator.
  Assumes a 12-bit data memory space and a 32-bit AXI4-Lite register bus.
*/
package addr_gen_pkg;
  // Data memory layout
  localparam int          DATA_ADDR_W   = 12;
  localparam logic [7:0]  ACCESS_LIMIT  = 8'h5F;
  localparam logic [11:0] SFR_BASE      = 12'hF00;
  localparam logic [3:0]  BANK_RESET    = 4'h0;
  localparam logic [11:0] SFP_RESET     = 12'h000;
  localparam int          EXT_OP_COUNT  = 8;
  localparam int          EXT_OP_W      = 3;

  // Register map (byte addresses)
  localparam int          AXI_ADDR_W    = 8;
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_BANK      = 8'h04;
  localparam logic [7:0]  OFF_SFP       = 8'h08;
  localparam logic [7:0]  OFF_STATUS    = 8'h0C;
  localparam int          CTRL_EXT_BIT  = 0;
  localparam int          STAT_CNT_LSB  = 16;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Request from the decode stage
  typedef struct packed {
    logic [7:0]          operand;
    logic                access_sel;
    logic                dest_sel;
    logic                uses_access;
    logic                ext_op;
    logic [EXT_OP_W-1:0] ext_op_idx;
  } addr_req_t;

  // Answer toward data memory
  typedef struct packed {
    logic [DATA_ADDR_W-1:0] addr;
    logic                   dest_file;
    logic                   indexed;
    logic                   illegal_op;
  } addr_rsp_t;
endpackage

// >>> verilog/indexed_offset_address_gen.sv
/*
  Effective data-address generator for byte- and bit-oriented instructions,
  with registers reached over AXI4-Lite.
  Assumes decode presents one request per cycle at most, synchronous to aclk.
*/
// How it works
// - Ext off, a=0: literal access-region address.
// - Ext off, a=1: bank pointer selects bank.
// - Ext on, a=0, f<=5Fh: offset from frame pointer.
// - Operands above 5Fh keep literal meaning.
// - Enable unlocks eight ops and indexed mode.
// - Destination bit handled as in standard mode.
// - Frame pointer zero restores access-region mapping.
// - Substitution covers every access-bit instruction.
`timescale 1ns/1ps
module indexed_offset_address_gen (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Decode request
  input  wire logic                   req_valid,
  input  wire addr_gen_pkg::addr_req_t req,
  // Memory answer
  output logic                        rsp_valid,
  output addr_gen_pkg::addr_rsp_t     rsp,
  // Mode flag
  output logic                        ext_enabled
);

  typedef struct packed {
    logic                     ext_en;
    logic [3:0]               bank;
    logic [11:0]              sfp;
    logic                     aw_got;
    logic [7:0]               aw_addr;
    logic                     w_got;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    logic                     rsp_valid;
    addr_gen_pkg::addr_rsp_t  rsp;
    logic [15:0]              idx_count;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic                             use_idx;
  logic [addr_gen_pkg::DATA_ADDR_W-1:0] eff_addr;
  logic                             do_write;
  logic [7:0]                       wa;
  logic [31:0]                      wd;
  logic [3:0]                       ws;

  // Address selection
  always_comb begin
    use_idx = state_reg.ext_en && req.uses_access && !req.access_sel
              && (req.operand <= addr_gen_pkg::ACCESS_LIMIT);
    if (use_idx) begin
      eff_addr = state_reg.sfp + {4'h0, req.operand};
    end else if (req.uses_access && req.access_sel) begin
      eff_addr = {state_reg.bank, req.operand};
    end else if (req.operand <= addr_gen_pkg::ACCESS_LIMIT) begin
      eff_addr = {4'h0, req.operand};
    end else begin
      eff_addr = addr_gen_pkg::SFR_BASE | {4'h0, req.operand};
    end
  end

  always_comb begin
    state_next = state_reg;
    do_write   = 1'b0;
    wa         = state_reg.aw_addr;
    wd         = state_reg.wdata;
    ws         = state_reg.wstrb;

    // Write channel capture
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_got  = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
      wa                 = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
      wd               = s_axi_wdata;
      ws               = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_next.aw_got && state_next.w_got && !state_next.bvalid) begin
      do_write          = 1'b1;
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = addr_gen_pkg::RESP_OKAY;
      case (wa)
        addr_gen_pkg::OFF_CTRL: begin
          if (ws[0]) begin
            state_next.ext_en = wd[addr_gen_pkg::CTRL_EXT_BIT];
          end
        end
        addr_gen_pkg::OFF_BANK: begin
          if (ws[0]) begin
            state_next.bank = wd[3:0];
          end
        end
        addr_gen_pkg::OFF_SFP: begin
          if (ws[0]) begin
            state_next.sfp[7:0] = wd[7:0];
          end
          if (ws[1]) begin
            state_next.sfp[11:8] = wd[11:8];
          end
        end
        addr_gen_pkg::OFF_STATUS: begin
          state_next.bresp = addr_gen_pkg::RESP_OKAY;
        end
        default: begin
          state_next.bresp = addr_gen_pkg::RESP_SLVERR;
        end
      endcase
    end
    state_next.awready = !state_next.aw_got && !state_next.bvalid;
    state_next.wready  = !state_next.w_got && !state_next.bvalid;

    // Read channel
    if (s_axi_rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = addr_gen_pkg::RESP_OKAY;
      state_next.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        addr_gen_pkg::OFF_CTRL:   state_next.rdata[0] = state_reg.ext_en;
        addr_gen_pkg::OFF_BANK:   state_next.rdata[3:0] = state_reg.bank;
        addr_gen_pkg::OFF_SFP:    state_next.rdata[11:0] = state_reg.sfp;
        addr_gen_pkg::OFF_STATUS: begin
          state_next.rdata[11:0] = state_reg.rsp.addr;
          state_next.rdata[addr_gen_pkg::STAT_CNT_LSB +: 16] = state_reg.idx_count;
        end
        default: state_next.rresp = addr_gen_pkg::RESP_SLVERR;
      endcase
    end
    state_next.arready = !state_next.rvalid;

    // Address answer, one cycle after request
    state_next.rsp_valid = req_valid;
    if (req_valid) begin
      state_next.rsp.addr = eff_addr;
      state_next.rsp.dest_file = req.dest_sel;
      state_next.rsp.indexed   = use_idx;
      // extra ops legal only when enabled
      state_next.rsp.illegal_op = req.ext_op && !state_reg.ext_en;
      if (use_idx) begin
        state_next.idx_count = state_reg.idx_count + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg         <= '0;
      state_reg.bank    <= addr_gen_pkg::BANK_RESET;
      state_reg.sfp     <= addr_gen_pkg::SFP_RESET;
      state_reg.awready <= 1'b1;
      state_reg.wready  <= 1'b1;
      state_reg.arready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready  = state_reg.wready;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;
  assign rsp_valid     = state_reg.rsp_valid;
  assign rsp           = state_reg.rsp;
  assign ext_enabled   = state_reg.ext_en;

endmodule

// >>> test/addr_gen_monitor.sv
/* Checker on the generator ports; the bind follows the module. */
`timescale 1ns/1ps
module addr_gen_monitor (
  // Watched ports
  input logic                    aclk,
  input logic                    aresetn,
  input logic                    s_axi_arvalid,
  input logic                    s_axi_arready,
  input logic                    s_axi_rvalid,
  input logic                    req_valid,
  input addr_gen_pkg::addr_req_t req,
  input logic                    rsp_valid,
  input addr_gen_pkg::addr_rsp_t rsp,
  input logic                    ext_enabled
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire        hit = ext_enabled & req.uses_access & !req.access_sel & (req.operand <= 8'h5F);
  wire        by_bank = req.uses_access & req.access_sel;
  wire [11:0] lit = {(req.operand <= 8'h5F) ? 4'h0 : 4'hF, req.operand};
  sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
  chk_pulse_step: assert property (rsp_valid == $past(req_valid))
    else $error("answer pulse misplaced");
  chk_index_sel: assert property (req_valid |=> rsp.indexed == $past(hit))
    else $error("indexed choice wrong");
  chk_literal_map: assert property (req_valid && !hit && !by_bank
    |=> rsp.addr == $past(lit)) else $error("literal address wrong");
  chk_bank_low: assert property (req_valid && by_bank
    |=> rsp.addr[7:0] == $past(req.operand)) else $error("bank offset wrong");
  chk_dest_same: assert property (req_valid
    |=> rsp.dest_file == $past(req.dest_sel)) else $error("destination changed");
  chk_ext_ops: assert property (req_valid
    |=> rsp.illegal_op == $past(req.ext_op & !ext_enabled)) else $error("op flag wrong");
  chk_read_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_read_gate: assert property (s_axi_arready != s_axi_rvalid)
    else $error("read ready wrong");
endmodule
bind indexed_offset_address_gen addr_gen_monitor u_addr_gen_monitor (.*);

// >>> test/decode_model.sv
/* Decode stage model; the bench picks each request word. */
`timescale 1ns/1ps
module decode_model (
  // Clock, reset, bench side, block side
  input  logic                    aclk,
  input  logic                    aresetn,
  input  logic                    issue,
  input  addr_gen_pkg::addr_req_t next_req,
  output logic                    req_valid,
  output addr_gen_pkg::addr_req_t req
);
  always_ff @(posedge aclk) begin
    req_valid <= aresetn & issue;
    req       <= issue ? next_req : ~next_req;
  end
endmodule

// >>> test/testbench.sv
/* Self-checking bench; needs package, design, model and checker first. */
`timescale 1ns/1ps
module testbench;
  logic        aclk, aresetn, issue, ext, req_valid, rsp_valid, ext_enabled, fin, ix;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  bank;
  logic [4:0]  nv;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [11:0] sfp, ea, last_ea;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          n_errors, tests_run, seed, n_idx;
  addr_gen_pkg::addr_req_t next_req, req, r;
  addr_gen_pkg::addr_rsp_t rsp, exp_q[$];
  indexed_offset_address_gen u_indexed_offset_address_gen (.*, .s_axi_awprot(3'h0),
    .s_axi_arprot(3'h0), .s_axi_wstrb(4'hF));
  decode_model u_decode_model (.*);
  initial forever #2.5 aclk = ~aclk;
  task automatic check(input string name, input logic [31:0] seen, want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(negedge aclk) if (rsp_valid) begin
    if (exp_q.size() == 0) check("spare answer", 32'h1, 32'h0);
    else check("answer", 32'(rsp), 32'(exp_q.pop_front()));
  end
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      r = addr_gen_pkg::addr_req_t'(15'($random(seed)));
      if (i < 4) r = {8'h5E + 8'(i), 7'h10};
      ea = {(r.operand <= 8'h5F) ? 4'h0 : 4'hF, r.operand};
      if (r.uses_access & r.access_sel) ea = {bank, r.operand};
      ix = ext & r.uses_access & !r.access_sel & (r.operand <= 8'h5F);
      if (ix) ea = sfp + 12'(r.operand);
      n_idx += int'(ix);
      last_ea = ea;
      @(posedge aclk);
      {issue, next_req} <= {1'b1, r};
      exp_q.push_back({ea, r.dest_sel, ix, r.ext_op & !ext});
    end
    @(posedge aclk);
    issue <= 1'b0;
  endtask
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, e);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    nv  = {wr, wr, !wr, wr, !wr};
    fin = 1'b0;
    forever begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} <= nv;
      if (fin) break;
      @(negedge aclk);
      fin = wr ? s_axi_bvalid : s_axi_rvalid;
      nv  = nv & ~{s_axi_awready, s_axi_wready, s_axi_arready, fin, fin};
      if (fin) check("response", 32'(wr ? s_axi_bresp : s_axi_rresp), e);
      if (fin && !wr) check("read data", s_axi_rdata, d);
      @(posedge aclk);
    end
  endtask
  initial begin
    {aclk, aresetn, issue, ext, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, next_req} = '0;
    {bank, sfp, n_errors, tests_run, n_idx} = '0;
    seed = 32'h0031;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) axi(1'b0, 8'(4 * i), 32'h0, (i == 4) ? 32'h2 : 32'h0);
    axi(1'b1, 8'h14, 32'h1, 32'h2);
    for (int m = 0; m < 4; m++) begin
      ext  = (m != 0);
      bank = 4'(3 * m + 2);
      sfp  = (m == 3) ? 12'hFC0 : (m == 2) ? 12'h123 : 12'h000;
      axi(1'b1, 8'h00, 32'(ext), 32'h0);
      axi(1'b1, 8'h04, 32'(bank), 32'h0);
      axi(1'b1, 8'h08, 32'(sfp), 32'h0);
      check("mode", 32'(ext_enabled), 32'(ext));
      axi(1'b0, 8'h04, 32'(bank), 32'h0);
      axi(1'b0, 8'h08, 32'(sfp), 32'h0);
      burst(24);
      repeat (3) @(posedge aclk);
    end
    axi(1'b0, 8'h0C, {16'(n_idx), 4'h0, last_ea}, 32'h0);
    check("pending answers", 32'(exp_q.size()), 32'h0);
    complete_run;
  end
  initial begin
    #50000;
    n_errors++;
    complete_run;
  end
endmodule
